// [hw/wdt_pkg.sv]
// Watchdog register map, field positions and reset values
package wdt_pkg;
  // Register byte offsets
  localparam logic [11:0] WDT_LOAD_OFF   = 12'h000;
  localparam logic [11:0] WDT_VALUE_OFF  = 12'h004;
  localparam logic [11:0] WDT_CTRL_OFF   = 12'h008;
  localparam logic [11:0] WDT_ICLR_OFF   = 12'h00c;
  localparam logic [11:0] WDT_RIS_OFF    = 12'h010;
  localparam logic [11:0] WDT_MIS_OFF    = 12'h014;
  localparam logic [11:0] WDT_TEST_OFF   = 12'h018;
  localparam logic [11:0] WDT_LOCK_OFF   = 12'h01c;
  // Control field positions
  localparam int WDT_CTRL_INTEN_BIT = 0;
  localparam int WDT_CTRL_RESEN_BIT = 1;
  localparam int WDT_CTRL_NMI_BIT   = 2;
  // Test register field position
  localparam int WDT_TEST_STALL_BIT = 8;
  // Lock register key and readback values
  // Unlock key value is arbitrary
  localparam logic [31:0] WDT_UNLOCK_KEY  = 32'h0000a5a5;
  localparam logic [31:0] WDT_LOCKED_RD   = 32'h00000001;
  localparam logic [31:0] WDT_UNLOCKED_RD = 32'h00000000;
  // Reset values
  localparam logic [31:0] WDT_LOAD_RST  = 32'hffffffff;
  localparam logic [31:0] WDT_VALUE_RST = 32'hffffffff;
endpackage

// [hw/wdt_counter.sv]
// Watchdog countdown counter with reload and stall
`timescale 1ns/1ps
module wdt_counter
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control
  input  wire logic        run,
  input  wire logic        stall,
  input  wire logic        load_now,
  input  wire logic [31:0] load_val,
  input  wire logic [31:0] reload_value,
  // Status
  output logic [31:0]      count,
  output logic             zero_hit
);
  typedef struct packed {
    logic [31:0] count;
    logic        zero_hit;
  } wdt_cnt_s;

  wdt_cnt_s st;
  wdt_cnt_s next_st;

  always_comb begin
    next_st          = st;
    next_st.zero_hit = 1'b0;
    if (load_now) begin
      next_st.count = load_val;
    end else if (run && !stall) begin
      if (st.count == 32'h00000000) begin
        next_st.count    = reload_value;
        next_st.zero_hit = 1'b1;
      end else begin
        next_st.count = st.count - 32'h00000001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{count: WDT_VALUE_RST, zero_hit: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign count    = st.count;
  assign zero_hit = st.zero_hit;
endmodule

// [hw/wdt_top.sv]
// Watchdog timer with APB register interface
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module wdt_top
  import wdt_pkg::*;
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Debug halt input
  input  wire logic        cpu_halted,
  // Outputs to the system
  output logic             wdt_irq,
  output logic             wdt_nmi,
  output logic             cpu_reset_req
);
  typedef struct packed {
    logic [31:0] reload_value;
    logic        inten;
    logic        resen;
    logic        nmi_sel;
    logic        stall_en;
    logic        locked;
    logic        raw_int;
    logic        reset_out;
    logic        irq;
    logic        nmi;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } wdt_regs_s;

  wdt_regs_s st;
  wdt_regs_s next_st;

  logic [31:0] count;
  logic        zero_hit;
  logic        wr;
  logic        rd_phase;
  logic        cfg_ok;
  logic        load_wr;
  logic        masked_status_select;

  // Writes land at the access edge, where ready is seen high
  assign wr       = psel && penable && pwrite && st.pready;
  assign rd_phase = psel && !penable && !pwrite;
  assign cfg_ok   = !st.locked;
  assign load_wr  = wr && cfg_ok && (paddr == WDT_LOAD_OFF) && st.inten;

  wdt_counter u_cnt (
    .pclk         (pclk),
    .presetn      (presetn),
    .run          (st.inten),
    .stall        (st.stall_en && cpu_halted),
    .load_now     (load_wr),
    .load_val     (pwdata),
    .reload_value (st.reload_value),
    .count        (count),
    .zero_hit     (zero_hit)
  );

  always_comb begin
    next_st         = st;
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    masked_status_select = (paddr == WDT_MIS_OFF);
    // Timeout events; the set wins over a clear in the same cycle
    if (zero_hit) begin
      if (st.raw_int && st.resen) begin
        next_st.reset_out = 1'b1;
      end
    end
    if (wr && paddr == WDT_ICLR_OFF) begin
      next_st.raw_int = 1'b0;
    end
    if (wr && cfg_ok) begin
      case (paddr)
        WDT_LOAD_OFF: begin
          next_st.reload_value = pwdata;
          if (pwdata == 32'h00000000) begin
            next_st.raw_int = 1'b1;
          end
        end
        WDT_CTRL_OFF: begin
          // Enable is sticky: starts counter and interrupt together
          if (pwdata[WDT_CTRL_INTEN_BIT]) begin
            next_st.inten = 1'b1;
          end
          next_st.resen = pwdata[WDT_CTRL_RESEN_BIT];
          if (pwdata[WDT_CTRL_NMI_BIT]) begin
            next_st.nmi_sel = 1'b1;
          end
        end
        WDT_TEST_OFF: next_st.stall_en = pwdata[WDT_TEST_STALL_BIT];
        default: ;
      endcase
    end
    if (wr && paddr == WDT_LOCK_OFF) begin
      next_st.locked = (pwdata != WDT_UNLOCK_KEY);
    end
    if (zero_hit) begin
      next_st.raw_int = 1'b1;
    end
    next_st.irq = next_st.raw_int && next_st.inten && !next_st.nmi_sel;
    next_st.nmi = next_st.raw_int && next_st.inten && next_st.nmi_sel;
    // Read data, answered one cycle after setup
    if (psel && !penable) begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h00000000;
      if (rd_phase) begin
        case (paddr)
          WDT_LOAD_OFF:  next_st.prdata = st.reload_value;
          WDT_VALUE_OFF: next_st.prdata = count;
          WDT_CTRL_OFF:  next_st.prdata = {29'h0, st.nmi_sel, st.resen, st.inten};
          WDT_RIS_OFF:   next_st.prdata = {31'h0, st.raw_int};
          WDT_MIS_OFF:   next_st.prdata = {31'h0, st.raw_int && st.inten
                                           && masked_status_select};
          WDT_TEST_OFF:  next_st.prdata = {23'h0, st.stall_en, 8'h00};
          WDT_LOCK_OFF:  next_st.prdata = st.locked ? WDT_LOCKED_RD : WDT_UNLOCKED_RD;
          WDT_ICLR_OFF:  next_st.prdata = 32'h00000000;
          default:       next_st.pslverr = 1'b1;
        endcase
      end else begin
        case (paddr)
          WDT_LOAD_OFF, WDT_CTRL_OFF, WDT_ICLR_OFF, WDT_TEST_OFF,
          WDT_LOCK_OFF:  next_st.pslverr = 1'b0;
          WDT_VALUE_OFF, WDT_RIS_OFF, WDT_MIS_OFF: next_st.pslverr = 1'b0;
          default:       next_st.pslverr = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{reload_value: WDT_LOAD_RST, prdata: 32'h00000000, default: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign prdata        = st.prdata;
  assign pready        = st.pready;
  assign pslverr       = st.pslverr;
  assign wdt_irq       = st.irq;
  assign wdt_nmi       = st.nmi;
  assign cpu_reset_req = st.reset_out;
endmodule

// [bench/wdt_top_props.sv]
// Assertions on the watchdog top ports
`timescale 1ns/1ps
module wdt_top_props
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // System outputs
  input wire logic        wdt_irq,
  input wire logic        wdt_nmi,
  input wire logic        cpu_reset_req
);
  wire logic mapped = paddr inside {WDT_LOAD_OFF, WDT_VALUE_OFF, WDT_CTRL_OFF, WDT_ICLR_OFF,
                                    WDT_RIS_OFF, WDT_MIS_OFF, WDT_TEST_OFF, WDT_LOCK_OFF};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_ack; s_setup |=> pready && penable; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_src; pready |-> $past(psel && !penable); endproperty
  property p_err; s_setup ##0 !mapped |=> pslverr; endproperty
  property p_ok; s_setup ##0 mapped |=> !pslverr; endproperty
  property p_excl; !(wdt_irq && wdt_nmi); endproperty
  property p_hold; cpu_reset_req |=> cpu_reset_req; endproperty
  property p_cause; $rose(cpu_reset_req) |-> $past(wdt_irq || wdt_nmi); endproperty
  a_ack: assert property (p_ack) else $error("no ready after setup");
  a_pulse: assert property (p_pulse) else $error("ready too long");
  a_src: assert property (p_src) else $error("ready without setup");
  a_err: assert property (p_err) else $error("unmapped not flagged");
  a_ok: assert property (p_ok) else $error("mapped flagged");
  a_excl: assert property (p_excl) else $error("irq and nmi both");
  a_hold: assert property (p_hold) else $error("reset request dropped");
  a_cause: assert property (p_cause) else $error("reset without timeout");
endmodule

// [bench/tb_watchdog_timer_control.sv]
// Self-checking bench for the watchdog top
`timescale 1ns/1ps
module tb_watchdog_timer_control;
  import wdt_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cpu_halted = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, v1, v2, ld;
  logic        pready, pslverr, wdt_irq, wdt_nmi, cpu_reset_req;
  logic [33:0] exp_q[$];
  int          err_total = 0, check_count = 0;
  always #2 pclk = ~pclk;
  wdt_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                 .pready, .pslverr, .cpu_halted, .wdt_irq, .wdt_nmi, .cpu_reset_req);
  task automatic fail(input string m);
    $display("[ERR] %0t %s", $time, m);
    err_total++;
  endtask
  task automatic chk(input logic c, input string m);
    check_count++;
    if (c !== 1'b1) fail(m);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (pready === 1'b1 && exp_q.size() > 0) begin
      logic [33:0] e;
      e = exp_q.pop_front();
      check_count++;
      if (pslverr !== e[32] || (e[33] && prdata !== e[31:0])) fail("apb answer");
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [33:0] e);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    psel <= 0;
    penable <= 0;
    if (n >= 20) begin
      fail("apb hang");
      conclude();
    end
  endtask
  task automatic wait_hi(input logic rst_sel);
    repeat (200) begin
      @(posedge pclk);
      if ((rst_sel ? cpu_reset_req : wdt_irq) === 1'b1) return;
    end
    fail("wait hang");
    conclude();
  endtask
  task automatic rst();
    presetn <= 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
  endtask
  initial begin
    void'($urandom(32'h7b90));
    rst();
    apb(0, WDT_LOAD_OFF, 0, {2'b10, WDT_LOAD_RST});
    apb(0, WDT_VALUE_OFF, 0, {2'b10, WDT_VALUE_RST});
    apb(0, WDT_CTRL_OFF, 0, {2'b10, 32'h0});
    apb(0, WDT_LOCK_OFF, 0, {2'b10, WDT_UNLOCKED_RD});
    apb(0, 12'h020, 0, 34'h100000000);
    $display("reset test done");
    apb(1, WDT_CTRL_OFF, 32'h3, 0);
    apb(0, WDT_CTRL_OFF, 0, {2'b10, 32'h3});
    ld = 32'd100 + ($urandom % 64);
    apb(1, WDT_LOAD_OFF, ld, 0);
    apb(0, WDT_VALUE_OFF, 0, 0);
    v1 = rd;
    chk(v1 < ld && v1 + 8 > ld, "load");
    apb(1, WDT_TEST_OFF, 32'h1 << WDT_TEST_STALL_BIT, 0);
    cpu_halted <= 1;
    apb(0, WDT_VALUE_OFF, 0, 0);
    v1 = rd;
    apb(0, WDT_VALUE_OFF, 0, 0);
    chk(rd === v1, "stall");
    cpu_halted <= 0;
    apb(0, WDT_VALUE_OFF, 0, 0);
    chk(rd < v1, "resume");
    apb(1, WDT_TEST_OFF, 0, 0);
    cpu_halted <= 1;
    apb(0, WDT_VALUE_OFF, 0, 0);
    v2 = rd;
    chk(v2 < v1 && v2 + 8 > v1 - 8, "no stall");
    apb(0, WDT_VALUE_OFF, 0, 0);
    chk(rd < v2, "halted but counting");
    cpu_halted <= 0;
    $display("count test done");
    apb(1, WDT_LOAD_OFF, 32'd60, 0);
    wait_hi(0);
    apb(0, WDT_VALUE_OFF, 0, 0);
    chk(rd <= 60 && rd > 50, "reload");
    apb(0, WDT_MIS_OFF, 0, {2'b10, 32'h1});
    apb(1, WDT_ICLR_OFF, 0, 0);
    apb(0, WDT_RIS_OFF, 0, {2'b10, 32'h0});
    wait_hi(0);
    chk(cpu_reset_req === 1'b0, "cleared");
    wait_hi(1);
    $display("timeout test done");
    rst();
    apb(1, WDT_LOCK_OFF, 0, 0);
    apb(0, WDT_LOCK_OFF, 0, {2'b10, WDT_LOCKED_RD});
    apb(1, WDT_LOAD_OFF, 32'h5, 0);
    apb(1, WDT_CTRL_OFF, 32'h1, 0);
    apb(0, WDT_LOAD_OFF, 0, {2'b10, WDT_LOAD_RST});
    apb(0, WDT_CTRL_OFF, 0, {2'b10, 32'h0});
    apb(1, WDT_LOCK_OFF, WDT_UNLOCK_KEY, 0);
    apb(1, WDT_CTRL_OFF, 32'h1, 0);
    apb(0, WDT_CTRL_OFF, 0, {2'b10, 32'h1});
    apb(1, WDT_LOAD_OFF, 0, 0);
    apb(0, WDT_RIS_OFF, 0, {2'b10, 32'h1});
    chk(wdt_irq === 1'b1, "normal irq");
    apb(1, WDT_CTRL_OFF, 32'h5, 0);
    repeat (3) @(posedge pclk);
    chk(wdt_nmi === 1'b1 && wdt_irq === 1'b0, "nmi");
    chk(cpu_reset_req === 1'b0, "no reset");
    $display("lock test done");
    conclude();
  end
endmodule
bind wdt_top wdt_top_props u_props (.pclk, .presetn, .psel, .penable, .paddr, .pready,
                                    .pslverr, .wdt_irq, .wdt_nmi, .cpu_reset_req);
